// ---- rtl/cpu_ready_defines.vh ----
`ifndef CPU_READY_DEFINES_VH
`define CPU_READY_DEFINES_VH

// system clock and processor clock rates
`define CLK_HZ            25000000
`define CPU_HZ            2600000
`define CPU_DIV           (`CLK_HZ / `CPU_HZ)
`define CPU_DIV_W         4

// command acknowledge timeout, in milliseconds and in clock cycles
`define TIMEOUT_MS        10
`define TIMEOUT_CYCLES    ((`CLK_HZ / 1000) * `TIMEOUT_MS)
`define TIMEOUT_W         18

// local acknowledge delay, in processor clock ticks
`define LOCAL_ACK_TICKS   3'h2
`define LOCAL_ACK_W       3

// register offsets
`define REG_CTRL          4'h0
`define REG_STATUS        4'h1
`define REG_TOCOUNT       4'h2

// control register fields and reset value
`define CTRL_ROM_EN       0
`define CTRL_OVERRIDE     1
`define CTRL_RESET        8'h02

// status register fields
`define STAT_READY        0
`define STAT_TIMEOUT      1
`define STAT_BUSY         2

// pin positions in the synchronised input vector
`define PIN_CYCLE_START   0
`define PIN_MEM_CYCLE     1
`define PIN_IO_CYCLE      2
`define PIN_RAM_SELECT    3
`define PIN_LOCAL_SELECT  4
`define PIN_EXT_ACK_N     5
`define PIN_ADV_ACK_N     6
`define PIN_INT_ACK_N     7
`define PIN_OTHER_REQ     8
`define PIN_COUNT         9

// resting levels of the synchronised pins: the active-low acknowledges idle high
`define PIN_IDLE          9'h0e0

`endif

// ---- rtl/cpu_ready_wait_state_logic.v ----
`default_nettype none
`include "cpu_ready_defines.vh"

// What this block does
// - Every memory access machine cycle gets at least one wait state from the ready logic.
// - The processor clock is generated at 25 MHz / 9, about 2.78 MHz, so the single wait state costs no average speed.
// - The acknowledges are synchronised one by one, then combined, and a register drives the processor ready pin.
// - The RAM access acknowledge is still low at the first ready sample in T2, forcing one wait state.
// - The RAM access acknowledge is high at the sample in the wait state, so the processor moves to T3.
// - External, advance, local and timeout acknowledges hold ready low until their operation completes.
// - A local timer makes the acknowledge for local I/O transfers.
// - If no acknowledge arrives within about 10 ms a timeout acknowledge raises ready.
// - In interrupt acknowledge cycles the interrupt acknowledge strobe itself supplies ready.
// - On the shared bus this board's processor yields to any other requesting master, except during its own external cycle while bus_override is set.
// - The boot ROM enable is set only through the control port that the own processor reaches.
module cpu_ready_wait_state_logic #(
  parameter TIMEOUT_CYCLES = `TIMEOUT_CYCLES
) (
  // clock and reset
  input  wire       clk,
  input  wire       rstn,
  // processor cycle status pins
  input  wire       cycle_start,
  input  wire       mem_cycle,
  input  wire       io_cycle,
  input  wire       ram_select,
  input  wire       local_io_select,
  // acknowledge pins
  input  wire       external_transfer_ack_n,
  input  wire       advance_ack_n,
  input  wire       interrupt_ack_n,
  // shared bus
  input  wire       other_bus_request,
  output reg        bus_request,
  // processor side
  output reg        cpu_clk,
  output reg        cpu_ready,
  output reg        rom_enable,
  output reg        bus_override,
  // register port
  input  wire [3:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_write,
  input  wire       reg_read,
  output reg  [7:0] reg_rdata
);

  localparam ST_IDLE = 2'b00;
  localparam ST_T2   = 2'b01;
  localparam ST_WAIT = 2'b10;

  // divider and timeout end points, cut to their counter widths on purpose
  localparam integer          DIV_LAST_I = `CPU_DIV - 1;
  localparam integer          DIV_HALF_I = `CPU_DIV / 2;
  localparam integer          TO_LAST_I  = TIMEOUT_CYCLES - 1;
  localparam [`CPU_DIV_W-1:0] DIV_LAST   = DIV_LAST_I[`CPU_DIV_W-1:0];
  localparam [`CPU_DIV_W-1:0] DIV_HALF   = DIV_HALF_I[`CPU_DIV_W-1:0];
  localparam [`TIMEOUT_W-1:0] TO_LAST    = TO_LAST_I[`TIMEOUT_W-1:0];

  // reset values of the control bits and of the pin synchronisers
  localparam [7:0]            CTRL_INIT  = `CTRL_RESET;
  localparam [`PIN_COUNT-1:0] PIN_IDLE_V = `PIN_IDLE;

  // register address match
  function hit;
    input [3:0] addr;
    input [3:0] offset;
    begin
      hit = (addr == offset);
    end
  endfunction

  wire [`PIN_COUNT-1:0] pins_raw;
  reg  [`PIN_COUNT-1:0] pins_meta;
  reg  [`PIN_COUNT-1:0] pins;
  reg                   start_prev;
  wire                  start_edge;

  reg  [`CPU_DIV_W-1:0] div_count;
  wire                  cpu_tick;

  reg  [1:0]            state;
  reg  [1:0]            next_state;
  reg                   cyc_mem;
  reg                   cyc_ram;
  reg                   cyc_local;
  reg                   cyc_ext;
  reg                   ram_access_ack;
  reg                   timeout_ack;
  reg  [`TIMEOUT_W-1:0] to_count;
  wire                  local_io_ack;
  wire                  cycle_end;
  wire                  any_ack;
  wire                  ext_ack;
  wire                  int_ack;

  reg                   timeout_seen;
  reg  [7:0]            timeout_total;
  wire                  wr_ctrl;
  wire                  wr_status;

  assign pins_raw = {other_bus_request, interrupt_ack_n, advance_ack_n, external_transfer_ack_n,
                     local_io_select, ram_select, io_cycle, mem_cycle, cycle_start};

  // two-flop synchronisers for every pin
  genvar g;
  generate
    for (g = 0; g < `PIN_COUNT; g = g + 1) begin : sync
      always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          pins_meta[g] <= PIN_IDLE_V[g];  // no false acknowledge after reset
          pins[g]      <= PIN_IDLE_V[g];
        end else begin
          pins_meta[g] <= pins_raw[g];
          pins[g]      <= pins_meta[g];
        end
      end
    end
  endgenerate

  // edge of the status strobe marks the start of a machine cycle
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      start_prev <= 1'b0;
    end else begin
      start_prev <= pins[`PIN_CYCLE_START];
    end
  end

  assign start_edge = pins[`PIN_CYCLE_START] & ~start_prev;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div_count <= {`CPU_DIV_W{1'b0}};
      cpu_clk   <= 1'b0;
    end else begin
      if (div_count == DIV_LAST) begin
        div_count <= {`CPU_DIV_W{1'b0}};
      end else begin
        div_count <= div_count + 4'h1;
      end
      cpu_clk <= (div_count < DIV_HALF);
    end
  end

  // ready is sampled by the processor once per processor clock
  assign cpu_tick = (div_count == DIV_LAST);

  // machine cycle sequencing
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (start_edge) begin
          next_state = ST_T2;
        end
      end
      ST_T2: begin
        if (cpu_tick) begin
          next_state = cpu_ready ? ST_IDLE : ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (cpu_tick && cpu_ready) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  assign cycle_end = (state != ST_IDLE) && (next_state == ST_IDLE);

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // capture the kind of machine cycle at its start
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cyc_mem   <= 1'b0;
      cyc_ram   <= 1'b0;
      cyc_local <= 1'b0;
      cyc_ext   <= 1'b0;
    end else if (state == ST_IDLE && start_edge) begin
      cyc_mem   <= pins[`PIN_MEM_CYCLE];
      cyc_ram   <= pins[`PIN_MEM_CYCLE] & pins[`PIN_RAM_SELECT];
      cyc_local <= pins[`PIN_IO_CYCLE] & pins[`PIN_LOCAL_SELECT];
      cyc_ext   <= (pins[`PIN_MEM_CYCLE] & ~pins[`PIN_RAM_SELECT]) |
                   (pins[`PIN_IO_CYCLE] & ~pins[`PIN_LOCAL_SELECT]);
    end
  end

  // ram acknowledge stays low through the T2 sample
  // and rises for the sample taken in the wait state
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ram_access_ack <= 1'b0;
    end else if (cycle_end || state == ST_IDLE) begin
      ram_access_ack <= 1'b0;
    end else if (state == ST_T2 && cpu_tick && cyc_ram) begin
      ram_access_ack <= 1'b1;
    end
  end

  // local acknowledge timer for local I/O transfers
  local_ack_timer local_ack_timer_inst (
    .clk          (clk),
    .rstn         (rstn),
    .start        (state == ST_IDLE && start_edge && pins[`PIN_IO_CYCLE] && pins[`PIN_LOCAL_SELECT]),
    .clear        (cycle_end),
    .tick         (cpu_tick),
    .local_io_ack (local_io_ack)
  );

  // timeout acknowledge after the command wait limit
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      to_count    <= {`TIMEOUT_W{1'b0}};
      timeout_ack <= 1'b0;
    end else if (state == ST_IDLE || cycle_end) begin
      to_count    <= {`TIMEOUT_W{1'b0}};
      timeout_ack <= 1'b0;
    end else if (to_count == TO_LAST) begin
      timeout_ack <= 1'b1;
    end else begin
      to_count <= to_count + 18'h1;
    end
  end

  // external and advance acknowledges only count for external cycles
  assign ext_ack = cyc_ext & (~pins[`PIN_EXT_ACK_N] | ~pins[`PIN_ADV_ACK_N]);

  assign int_ack = ~pins[`PIN_INT_ACK_N] & ~cyc_mem;

  assign any_ack = ram_access_ack | ext_ack | local_io_ack | timeout_ack | int_ack;

  // registered ready straight to the processor
  // ready is held low through T2 of memory cycles so they wait at least once
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cpu_ready <= 1'b0;
    end else if (cycle_end || next_state == ST_IDLE) begin
      cpu_ready <= 1'b0;
    end else if (state == ST_T2 && cyc_mem) begin
      cpu_ready <= 1'b0;
    end else begin
      cpu_ready <= any_ack;
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bus_request <= 1'b0;
    end else if (state != ST_IDLE && cyc_ext) begin
      bus_request <= ~pins[`PIN_OTHER_REQ] | (bus_override & bus_request);
    end else begin
      bus_request <= bus_request & bus_override & ~pins[`PIN_OTHER_REQ];
    end
  end

  assign wr_ctrl   = reg_write & hit(reg_addr, `REG_CTRL);
  assign wr_status = reg_write & hit(reg_addr, `REG_STATUS);

  // rom enable written only through the local control port
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rom_enable   <= CTRL_INIT[`CTRL_ROM_EN];
      bus_override <= CTRL_INIT[`CTRL_OVERRIDE];
    end else if (wr_ctrl) begin
      rom_enable   <= reg_wdata[`CTRL_ROM_EN];
      bus_override <= reg_wdata[`CTRL_OVERRIDE];
    end
  end

  // timeout flag and count; a new timeout wins over a clear
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      timeout_seen  <= 1'b0;
      timeout_total <= 8'h00;
    end else begin
      if (timeout_ack && cycle_end) begin
        timeout_seen <= 1'b1;
      end else if (wr_status && reg_wdata[`STAT_TIMEOUT]) begin
        timeout_seen <= 1'b0;
      end
      if (timeout_ack && cycle_end && timeout_total != 8'hff) begin
        timeout_total <= timeout_total + 8'h01;
      end
    end
  end

  // read data one cycle after the read strobe, zero otherwise
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      if (hit(reg_addr, `REG_CTRL)) begin
        reg_rdata <= {6'h00, bus_override, rom_enable};
      end else if (hit(reg_addr, `REG_STATUS)) begin
        reg_rdata <= {5'h00, state != ST_IDLE, timeout_seen, cpu_ready};
      end else if (hit(reg_addr, `REG_TOCOUNT)) begin
        reg_rdata <= timeout_total;
      end else begin
        reg_rdata <= 8'h00;
      end
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule

`default_nettype wire

// ---- rtl/local_ack_timer.v ----
`default_nettype none

module local_ack_timer (
  // clock and reset
  input  wire       clk,
  input  wire       rstn,
  // control
  input  wire       start,
  input  wire       clear,
  input  wire       tick,
  // acknowledge out
  output reg        local_io_ack
);

`include "cpu_ready_defines.vh"

  reg [`LOCAL_ACK_W-1:0] count;
  reg                    running;

  // counts processor ticks from start, then holds the acknowledge until cleared
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count        <= {`LOCAL_ACK_W{1'b0}};
      running      <= 1'b0;
      local_io_ack <= 1'b0;
    end else if (clear) begin
      count        <= {`LOCAL_ACK_W{1'b0}};
      running      <= 1'b0;
      local_io_ack <= 1'b0;
    end else if (start) begin
      count        <= {`LOCAL_ACK_W{1'b0}};
      running      <= 1'b1;
    end else if (running && tick) begin
      if (count == `LOCAL_ACK_TICKS - 3'h1) begin
        running      <= 1'b0;
        local_io_ack <= 1'b1;
      end else begin
        count <= count + 3'h1;
      end
    end
  end

endmodule

`default_nettype wire

// ---- tb/ack_responder.sv ----
`default_nettype none
module ack_responder #(
  parameter int DELAY = 30
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // cycle strobe and acknowledge choice
  input  wire logic       cycle_start,
  input  wire logic [1:0] mode,
  // acknowledges, idle high
  output logic            ext_ack_n,
  output logic            adv_ack_n,
  output logic            int_ack_n
);
  timeunit 1ns;
  timeprecision 1ns;
  int   cnt;
  logic hit;
  // target answers late, holds ack until the strobe drops
  always @(posedge clk or negedge rstn) begin
    if (!rstn) cnt <= 0;
    else if (!cycle_start) cnt <= 0;
    else if (cnt < DELAY) cnt <= cnt + 1;
  end
  // interrupt strobe given in the same way
  assign hit = cycle_start && cnt >= DELAY;
  assign ext_ack_n = !(hit && mode == 2'h1);
  assign adv_ack_n = !(hit && mode == 2'h2);
  assign int_ack_n = !(hit && mode == 2'h3);
endmodule
`default_nettype wire

// ---- tb/cpu_ready_monitor.sv ----
`include "cpu_ready_defines.vh"
`default_nettype none
module cpu_ready_monitor (
  // clock, reset and pins
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic       cycle_start,
  input wire logic       mem_cycle,
  input wire logic       io_cycle,
  input wire logic       ram_select,
  input wire logic       local_io_select,
  input wire logic       external_transfer_ack_n,
  input wire logic       advance_ack_n,
  input wire logic       interrupt_ack_n,
  input wire logic       other_bus_request,
  // outputs watched
  input wire logic       bus_request,
  input wire logic       cpu_clk,
  input wire logic       cpu_ready,
  input wire logic       rom_enable,
  input wire logic       bus_override,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_write,
  input wire logic       reg_read,
  input wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking mc @(posedge clk); endclocking
  default disable iff (!rstn);
  a_clk_period: assert property (
    $rose(cpu_clk) |-> cpu_clk [*4] ##1 !cpu_clk [*5] ##1 cpu_clk) else $error("cpu clock period wrong");
  a_ready_hold: assert property (
    cpu_ready && cpu_clk |=> cpu_ready) else $error("ready dropped before tick");
  a_ready_bound: assert property (
    $rose(cpu_ready) |-> ##[1:9] !cpu_ready) else $error("ready held past one period");
  a_bus_yield: assert property (
    other_bus_request [*4] ##0 !bus_override |=> !bus_request) else $error("bus kept against request");
  a_ctrl_write: assert property (
    $changed(rom_enable) || $changed(bus_override) |-> $past(reg_write) && $past(reg_addr) == `REG_CTRL)
    else $error("control bit changed without write");
  a_ctrl_read: assert property (
    $past(reg_read) && $past(reg_addr) == `REG_CTRL |-> reg_rdata == {6'h00, $past(bus_override), $past(rom_enable)})
    else $error("control readback wrong");
  a_rdata_idle: assert property (
    !$past(reg_read) |-> reg_rdata == 8'h00) else $error("read data without read");
  a_unmapped_zero: assert property (
    $past(reg_read) && $past(reg_addr) > 4'h2 |-> reg_rdata == 8'h00) else $error("unmapped read not zero");
endmodule
`default_nettype wire

// ---- tb/cpu_ready_wait_state_logic_tb.sv ----
`include "cpu_ready_defines.vh"
`default_nettype none
module cpu_ready_wait_state_logic_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk, rstn, cs, mem, io, ram, loc, other, wr, rd;
  logic [1:0] mode;
  logic [3:0] addr;
  logic [7:0] wdata;
  wire logic  ext_n, adv_n, int_n, breq, cclk, rdy, rom, ovr;
  wire logic [7:0] rdata;
  int         err_total, checks, cyc, n, w;
  logic       held;
  // device and far side
  cpu_ready_wait_state_logic #(.TIMEOUT_CYCLES(50)) cpu_ready_wait_state_logic_inst (.clk(clk), .rstn(rstn),
    .cycle_start(cs), .mem_cycle(mem), .io_cycle(io), .ram_select(ram), .local_io_select(loc),
    .external_transfer_ack_n(ext_n), .advance_ack_n(adv_n), .interrupt_ack_n(int_n),
    .other_bus_request(other), .bus_request(breq), .cpu_clk(cclk), .cpu_ready(rdy), .rom_enable(rom),
    .bus_override(ovr), .reg_addr(addr), .reg_wdata(wdata), .reg_write(wr), .reg_read(rd), .reg_rdata(rdata));
  ack_responder ack_responder_inst (.clk(clk), .rstn(rstn), .cycle_start(cs), .mode(mode),
    .ext_ack_n(ext_n), .adv_ack_n(adv_n), .int_ack_n(int_n));
  task automatic report_and_stop();
    $display("errors=%0d checks=%0d", err_total, checks);
    if (err_total == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(logic [7:0] seen, logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic logic [7:0] in(int v, int lo, int hi);
    return {7'h00, v >= lo && v <= hi};
  endfunction
  task automatic wreg(logic [3:0] a, logic [7:0] d);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(logic [3:0] a, output logic [7:0] v);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  // one machine cycle: n cycles to ready, w cycles of ready
  task automatic run_cycle(logic m, logic i, logic r, logic l, logic [1:0] md);
    mem <= m;
    io <= i;
    ram <= r;
    loc <= l;
    mode <= md;
    cs <= 1'b1;
    n = 0;
    w = 0;
    while (rdy !== 1'b1 && n < 200) begin
      @(posedge clk);
      #1 n++;
    end
    held = breq;
    while (rdy === 1'b1 && w < 20) begin
      @(posedge clk);
      #1 w++;
    end
    cs <= 1'b0;
    repeat (20) @(posedge clk);
  endtask
  task automatic t_regs();
    logic [7:0] v;
    rreg(4'h0, v);
    check(v, 8'h02);
    rreg(4'hf, v);
    check(v, 8'h00);
    wreg(4'h0, 8'h01);
    rreg(4'h0, v);
    check(v, 8'h01);
    check({7'h00, rom}, 8'h01);
    wreg(4'h0, 8'h00);
  endtask
  // ram cycle: ready low at the T2 sample, then high for one processor period less a cycle
  task automatic t_ram();
    run_cycle(1'b1, 1'b0, 1'b1, 1'b0, 2'h0);
    check(in(n, 5, 13), 8'h01);
    check(in(w, `CPU_DIV - 1, `CPU_DIV - 1), 8'h01);
  endtask
  task automatic t_ext();
    run_cycle(1'b1, 1'b0, 1'b0, 1'b0, 2'h1);
    check(in(n, 30, 40), 8'h01);
    check(in(w, 1, 9), 8'h01);
    check({7'h00, held}, 8'h01);
    run_cycle(1'b0, 1'b1, 1'b0, 1'b0, 2'h2);
    check(in(n, 30, 40), 8'h01);
  endtask
  task automatic t_local_int();
    run_cycle(1'b0, 1'b1, 1'b0, 1'b1, 2'h0);
    check(in(n, 9, 30), 8'h01);
    run_cycle(1'b0, 1'b0, 1'b0, 1'b0, 2'h3);
    check(in(n, 30, 40), 8'h01);
  endtask
  task automatic t_timeout();
    logic [7:0] v;
    run_cycle(1'b1, 1'b0, 1'b0, 1'b0, 2'h0);
    check(in(n, 50, 60), 8'h01);
    rreg(4'h2, v);
    check(v, 8'h01);
    rreg(4'h1, v);
    check(v, 8'h02);
    wreg(4'h1, 8'h02);
    rreg(4'h1, v);
    check(v, 8'h00);
  endtask
  // bus held with override after an external cycle, then given up to a rival
  task automatic t_bus();
    wreg(4'h0, 8'h02);
    run_cycle(1'b1, 1'b0, 1'b0, 1'b0, 2'h1);
    #1 check({7'h00, breq}, 8'h01);
    other <= 1'b1;
    repeat (6) @(posedge clk);
    #1 check({7'h00, breq}, 8'h00);
    wreg(4'h0, 8'h00);
    repeat (6) @(posedge clk);
    other <= 1'b0;
  endtask
  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  // cuts a hang short
  initial begin
    cyc = 0;
    forever begin
      @(posedge clk);
      cyc++;
      if (cyc == 5000) begin
        err_total++;
        report_and_stop();
      end
    end
  end
  initial begin
    {rstn, cs, mem, io, ram, loc, other, wr, rd} = '0;
    mode = 2'h0;
    addr = 4'h0;
    wdata = 8'h00;
    err_total = 0;
    checks = 0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_regs();
    t_ram();
    t_ext();
    t_local_int();
    t_timeout();
    t_bus();
    report_and_stop();
  end
endmodule
bind cpu_ready_wait_state_logic cpu_ready_monitor mon_inst (.clk(clk), .rstn(rstn), .cycle_start(cycle_start),
  .mem_cycle(mem_cycle), .io_cycle(io_cycle), .ram_select(ram_select), .local_io_select(local_io_select),
  .external_transfer_ack_n(external_transfer_ack_n), .advance_ack_n(advance_ack_n),
  .interrupt_ack_n(interrupt_ack_n), .other_bus_request(other_bus_request), .bus_request(bus_request),
  .cpu_clk(cpu_clk), .cpu_ready(cpu_ready), .rom_enable(rom_enable), .bus_override(bus_override),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata));
`default_nettype wire
